// file: common/pkal_pkg.sv
package pkal_pkg;
  // --------------------------------------------------
  // Front panel keys (index into KEY)
  // --------------------------------------------------
  localparam int NKEY    = 15;
  localparam int K_ACK   = 0;
  localparam int K_RESET = 1;
  localparam int K_RUN   = 2;
  localparam int K_AUTO  = 3;
  localparam int K_STOP  = 4;
  localparam int K_ESC   = 5;
  localparam int K_UP    = 6;
  localparam int K_DOWN  = 7;
  localparam int K_LEFT  = 8;
  localparam int K_RIGHT = 9;
  localparam int K_OK    = 10;
  localparam int K_MENU  = 11;
  localparam int K_ACOV  = 12;
  localparam int K_ENGOV = 13;
  localparam int K_LOG   = 14;
  // Mode switch inputs (index into MODE_SW)
  localparam int MSW_RUN  = 0;
  localparam int MSW_AUTO = 1;
  localparam int MSW_STOP = 2;
  localparam int NEV      = 8;
  // --------------------------------------------------
  // Timing
  // --------------------------------------------------
  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned DEBOUNCE_MS   = 10;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned DEB_CYC_DEF   = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned BLINK_CYC_DEF = BLINK_HALF_MS * (CLK_HZ / 1000);
  localparam int          CNT_W         = 27;
  // --------------------------------------------------
  // Register map
  // --------------------------------------------------
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_STATUS = 8'h04;
  localparam logic [7:0]  OFS_WARN   = 8'h08;
  localparam logic [7:0]  OFS_SHUT   = 8'h0C;
  localparam logic [7:0]  OFS_SETPT  = 8'h10;
  localparam logic [7:0]  OFS_EDIT   = 8'h14;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam int CTRL_CAN_BIT = 0;
  localparam int CTRL_MSW_LSB = 1;
  localparam int CTRL_KIND_LSB = 4;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  localparam logic [2:0]  MAX_LEVEL   = 3'h7;
  localparam logic [3:0]  DIGIT_MAX   = 4'h9;
  typedef enum logic [1:0] {
    PKAL_STOP = 2'b00,
    PKAL_AUTO = 2'b01,
    PKAL_RUN  = 2'b10
  } pkal_mode_e;
  typedef enum logic [1:0] {
    KIND_NAV   = 2'b00,
    KIND_NUM   = 2'b01,
    KIND_LIST  = 2'b10,
    KIND_CHECK = 2'b11
  } pkal_kind_e;
  typedef enum logic [1:0] {
    LAMP_OFF   = 2'b00,
    LAMP_FLASH = 2'b01,
    LAMP_SOLID = 2'b10
  } pkal_lamp_e;
endpackage

// file: core/pkal_top.sv
`timescale 1ns/1ns
// Contract
// (R1) Acknowledge key switches horn relay off
// (R2) Acknowledge optionally sends global CAN silence
// (R3) Amber flashes while unacknowledged warnings remain
// (R4) Amber solid while acknowledged warnings active
// (R5) Acknowledge with no active warnings: amber off
// (R6) Red flashes while unacknowledged shutdowns active
// (R7) Acknowledge turns red flashing into solid
// (R8) Shutdown stays latched until manual reset
// (R9) Red off once no shutdown active
// (R10) Event reset clears only inactive faults
// (R11) Run key selects run mode
// (R12) Auto key selects automatic mode
// (R13) Stop key selects stop mode
// (R14) Active mode switch blocks other mode keys
// (R15) Escape discards edits, goes up one level
// (R16) Confirm in entry commits setpoint to memory
// (R17) Confirm in navigation descends one level
// (R18) Up increments digit or moves list up
// (R19) Down decrements digit or moves list down
// (R20) Left/right move the digit cursor
// (R21) Left/right invert a check box
// (R22) Main menu key jumps to top level
// (R23) One debounced press gives one action
// (R24) Shared free-running blink for both lamps
module pkal_top
  import pkal_pkg::*;
#(
  parameter int unsigned DEB_CYC   = pkal_pkg::DEB_CYC_DEF,
  parameter int unsigned BLINK_CYC = pkal_pkg::BLINK_CYC_DEF
) (
  // Clock and reset
  input  wire logic                     CLK,
  input  wire logic                     ARST_N,
  // Front panel and field inputs
  input  wire logic [pkal_pkg::NKEY-1:0] KEY,
  input  wire logic [pkal_pkg::NEV-1:0]  WARN_ACTIVE,
  input  wire logic [pkal_pkg::NEV-1:0]  SHUT_ACTIVE,
  input  wire logic [2:0]                MODE_SW,
  // Annunciation and control outputs
  output logic                           HORN,
  output logic                           AMBER_LAMP,
  output logic                           RED_LAMP,
  output logic                           CAN_SILENCE,
  output logic                           SHUTDOWN,
  output logic [1:0]                     MODE,
  output logic                           SAVE,
  // AXI4-Lite slave
  input  wire logic [7:0]                S_AXI_AWADDR,
  input  wire logic                      S_AXI_AWVALID,
  output logic                           S_AXI_AWREADY,
  input  wire logic [31:0]               S_AXI_WDATA,
  input  wire logic [3:0]                S_AXI_WSTRB,
  input  wire logic                      S_AXI_WVALID,
  output logic                           S_AXI_WREADY,
  output logic [1:0]                     S_AXI_BRESP,
  output logic                           S_AXI_BVALID,
  input  wire logic                      S_AXI_BREADY,
  input  wire logic [7:0]                S_AXI_ARADDR,
  input  wire logic                      S_AXI_ARVALID,
  output logic                           S_AXI_ARREADY,
  output logic [31:0]                    S_AXI_RDATA,
  output logic [1:0]                     S_AXI_RRESP,
  output logic                           S_AXI_RVALID,
  input  wire logic                      S_AXI_RREADY
);
  import pkal_pkg::*;

  localparam logic [CNT_W-1:0] DEB_LAST   = CNT_W'(DEB_CYC - 1);
  localparam logic [CNT_W-1:0] BLINK_LAST = CNT_W'(BLINK_CYC - 1);

  typedef struct packed {
    logic [NKEY-1:0]            stable;
    logic [NKEY-1:0]            press;
    logic [NKEY-1:0][CNT_W-1:0] deb;
    logic [CNT_W-1:0]           blink_cnt;
    logic                       blink;
    logic [NEV-1:0]             w_prev;
    logic [NEV-1:0]             w_lat;
    logic [NEV-1:0]             w_ack;
    logic [NEV-1:0]             s_prev;
    logic [NEV-1:0]             s_lat;
    logic [NEV-1:0]             s_ack;
    logic                       horn;
    logic                       can_sil;
    logic                       amber;
    logic                       red;
    logic                       shutdown;
    pkal_mode_e                 mode;
    logic [31:0]                ctrl;
    logic [2:0]                 level;
    logic [3:0]                 hilite;
    logic [1:0]                 screen;
    logic                       editing;
    pkal_kind_e                 kind;
    logic [1:0]                 cursor;
    logic [15:0]                wdig;
    logic [3:0]                 wlist;
    logic                       wchk;
    logic [15:0]                sdig;
    logic [3:0]                 slist;
    logic                       schk;
    logic                       save;
    logic                       aw_got;
    logic                       w_got;
    logic [7:0]                 awaddr;
    logic [31:0]                wdata;
    logic [3:0]                 wstrb;
    logic                       awready;
    logic                       wready;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       arready;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
  } pkal_state_s;

  pkal_state_s s;
  pkal_state_s next_s;

  // --------------------------------------------------
  // Derived views
  // --------------------------------------------------
  logic [NEV-1:0] w_rise;
  logic [NEV-1:0] s_rise;
  pkal_lamp_e     amber_st;
  pkal_lamp_e     red_st;
  logic           msw_run;
  logic           msw_auto;
  logic           msw_stop;
  logic [3:0]     dig;

  assign w_rise   = WARN_ACTIVE & ~s.w_prev;
  assign s_rise   = SHUT_ACTIVE & ~s.s_prev;
  assign msw_run  = MODE_SW[MSW_RUN]  & s.ctrl[CTRL_MSW_LSB + MSW_RUN];
  assign msw_auto = MODE_SW[MSW_AUTO] & s.ctrl[CTRL_MSW_LSB + MSW_AUTO];
  assign msw_stop = MODE_SW[MSW_STOP] & s.ctrl[CTRL_MSW_LSB + MSW_STOP];
  assign dig      = s.wdig[s.cursor*4 +: 4];

  always_comb begin
    // Unacknowledged latched warnings keep flashing even once inactive,
    // so the operator always sees them before the acknowledge.
    if (|(s.w_lat & ~s.w_ack)) begin
      amber_st = LAMP_FLASH; // R3
    end else if (|WARN_ACTIVE) begin
      amber_st = LAMP_SOLID; // R4
    end else begin
      amber_st = LAMP_OFF; // R5
    end
    if (|(SHUT_ACTIVE & ~s.s_ack)) begin
      red_st = LAMP_FLASH; // R6
    end else if (|SHUT_ACTIVE) begin
      red_st = LAMP_SOLID; // R7
    end else begin
      red_st = LAMP_OFF; // R9
    end
  end

  function automatic logic [31:0] rd_reg(input logic [7:0] a, input pkal_state_s st);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      OFS_CTRL:   v = st.ctrl;
      OFS_STATUS: v = {10'h000, st.kind, st.screen, st.hilite, st.cursor, st.editing,
                       st.level, st.shutdown, st.horn, red_st, amber_st, st.mode};
      OFS_WARN:   v = {8'h00, WARN_ACTIVE, st.w_ack, st.w_lat};
      OFS_SHUT:   v = {8'h00, SHUT_ACTIVE, st.s_ack, st.s_lat};
      OFS_SETPT:  v = {11'h000, st.schk, st.slist, st.sdig};
      OFS_EDIT:   v = {11'h000, st.wchk, st.wlist, st.wdig};
      default:    v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // --------------------------------------------------
  // Next state
  // --------------------------------------------------
  always_comb begin
    logic [31:0] wv;
    logic        hit;
    wv     = 32'h0000_0000;
    hit    = 1'b0;
    next_s = s;

    // Debounce: a key must differ from its stable level for a full
    // window before it is accepted; press is one cycle per accepted rise.
    for (int k = 0; k < NKEY; k++) begin
      next_s.press[k] = 1'b0;
      if (KEY[k] == s.stable[k]) begin
        next_s.deb[k] = '0;
      end else if (s.deb[k] == DEB_LAST) begin
        next_s.deb[k]    = '0;
        next_s.stable[k] = KEY[k];
        next_s.press[k]  = KEY[k]; // R23
      end else begin
        next_s.deb[k] = s.deb[k] + 1'b1;
      end
    end

    // One blink phase serves both lamps so they flash in step
    if (s.blink_cnt == BLINK_LAST) begin
      next_s.blink_cnt = '0;
      next_s.blink     = ~s.blink; // R24
    end else begin
      next_s.blink_cnt = s.blink_cnt + 1'b1;
    end

    // Fault latching, acknowledge and reset
    next_s.w_prev = WARN_ACTIVE;
    next_s.s_prev = SHUT_ACTIVE;
    next_s.w_lat  = s.w_lat | WARN_ACTIVE;
    next_s.s_lat  = s.s_lat | SHUT_ACTIVE; // R8
    if (s.press[K_RESET]) begin
      next_s.w_lat = WARN_ACTIVE | w_rise; // R10
      next_s.s_lat = SHUT_ACTIVE | s_rise; // R10
    end
    next_s.w_ack = s.w_ack;
    next_s.s_ack = s.s_ack;
    if (s.press[K_ACK]) begin
      next_s.w_ack = s.w_ack | s.w_lat; // R5
      next_s.s_ack = s.s_ack | s.s_lat; // R7
    end
    // A fresh activation is unacknowledged again, even in the ack cycle
    next_s.w_ack = next_s.w_ack & ~w_rise & next_s.w_lat;
    next_s.s_ack = next_s.s_ack & ~s_rise & next_s.s_lat;

    // Horn: new event sets it, acknowledge clears it, set wins
    if (|w_rise || |s_rise) begin
      next_s.horn = 1'b1;
    end else if (s.press[K_ACK]) begin
      next_s.horn = 1'b0; // R1
    end
    next_s.can_sil  = s.press[K_ACK] & s.ctrl[CTRL_CAN_BIT]; // R2
    next_s.shutdown = |next_s.s_lat; // R8
    next_s.amber    = (amber_st == LAMP_SOLID) | ((amber_st == LAMP_FLASH) & s.blink);
    next_s.red      = (red_st == LAMP_SOLID) | ((red_st == LAMP_FLASH) & s.blink);

    // Operating mode
    if (s.press[K_RUN] && !msw_auto && !msw_stop) begin // R14
      next_s.mode = PKAL_RUN; // R11
    end
    if (s.press[K_AUTO] && !msw_run && !msw_stop) begin // R14
      next_s.mode = PKAL_AUTO; // R12
    end
    if (s.press[K_STOP] && !msw_run && !msw_auto) begin // R14
      next_s.mode = PKAL_STOP; // R13
    end

    // Overview screens
    if (s.press[K_ACOV]) begin
      next_s.screen = 2'd1;
    end
    if (s.press[K_ENGOV]) begin
      next_s.screen = 2'd2;
    end
    if (s.press[K_LOG]) begin
      next_s.screen = 2'd3;
    end

    // Menu navigation and setpoint entry
    next_s.save = 1'b0;
    if (s.press[K_MENU]) begin
      next_s.level   = '0; // R22
      next_s.hilite  = '0;
      next_s.editing = 1'b0;
      next_s.screen  = '0;
    end else if (s.press[K_ESC]) begin
      next_s.editing = 1'b0; // R15
      next_s.wdig    = s.sdig;
      next_s.wlist   = s.slist;
      next_s.wchk    = s.schk;
      if (s.level != '0) begin
        next_s.level = s.level - 1'b1; // R15
      end
    end else if (s.press[K_OK]) begin
      if (s.editing) begin
        next_s.sdig    = s.wdig; // R16
        next_s.slist   = s.wlist;
        next_s.schk    = s.wchk;
        next_s.save    = 1'b1;
        next_s.editing = 1'b0;
      end else begin
        if (s.level != MAX_LEVEL) begin
          next_s.level = s.level + 1'b1; // R17
        end
        next_s.hilite = '0;
        next_s.kind   = pkal_kind_e'(s.ctrl[CTRL_KIND_LSB +: 2]);
        if (pkal_kind_e'(s.ctrl[CTRL_KIND_LSB +: 2]) != KIND_NAV) begin
          next_s.editing = 1'b1;
          next_s.cursor  = '0;
          next_s.wdig    = s.sdig;
          next_s.wlist   = s.slist;
          next_s.wchk    = s.schk;
        end
      end
    end else if (s.press[K_UP]) begin
      if (s.editing && s.kind == KIND_NUM) begin
        next_s.wdig[s.cursor*4 +: 4] = (dig >= DIGIT_MAX) ? 4'h0 : dig + 4'h1; // R18
      end else if (s.editing && s.kind == KIND_LIST) begin
        next_s.wlist = s.wlist - 4'h1; // R18
      end else if (!s.editing) begin
        next_s.hilite = s.hilite - 4'h1;
      end
    end else if (s.press[K_DOWN]) begin
      if (s.editing && s.kind == KIND_NUM) begin
        next_s.wdig[s.cursor*4 +: 4] = (dig == 4'h0 || dig > DIGIT_MAX) ? DIGIT_MAX : dig - 4'h1; // R19
      end else if (s.editing && s.kind == KIND_LIST) begin
        next_s.wlist = s.wlist + 4'h1; // R19
      end else if (!s.editing) begin
        next_s.hilite = s.hilite + 4'h1;
      end
    end else if (s.press[K_LEFT] || s.press[K_RIGHT]) begin
      if (s.editing && s.kind == KIND_NUM) begin
        // Cursor 0 is the units digit; left moves to higher digits
        next_s.cursor = s.press[K_LEFT] ? s.cursor + 2'd1 : s.cursor - 2'd1; // R20
      end else if (s.editing && s.kind == KIND_CHECK) begin
        next_s.wchk = ~s.wchk; // R21
      end
    end

    // AXI4-Lite write channel
    if (s.awready && S_AXI_AWVALID) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = S_AXI_AWADDR;
    end
    if (s.wready && S_AXI_WVALID) begin
      next_s.w_got = 1'b1;
      next_s.wdata = S_AXI_WDATA;
      next_s.wstrb = S_AXI_WSTRB;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = RESP_OKAY;
      wv = (s.awaddr == OFS_CTRL) ? s.ctrl : {11'h000, s.schk, s.slist, s.sdig};
      for (int b = 0; b < 4; b++) begin
        if (s.wstrb[b]) begin
          wv[b*8 +: 8] = s.wdata[b*8 +: 8];
        end
      end
      hit = (s.awaddr == OFS_CTRL) || (s.awaddr == OFS_SETPT);
      if (s.awaddr == OFS_CTRL) begin
        next_s.ctrl = wv;
      end else if (s.awaddr == OFS_SETPT) begin
        next_s.sdig  = wv[15:0];
        next_s.slist = wv[19:16];
        next_s.schk  = wv[20];
      end
      if (!hit) begin
        next_s.bresp = RESP_SLVERR;
      end
    end else if (s.bvalid && S_AXI_BREADY) begin
      next_s.bvalid = 1'b0;
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready  = !next_s.w_got && !next_s.bvalid;

    // AXI4-Lite read channel
    if (s.arready && S_AXI_ARVALID) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd_reg(S_AXI_ARADDR, s);
      next_s.rresp  = (S_AXI_ARADDR <= OFS_EDIT && S_AXI_ARADDR[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
    end else if (s.rvalid && S_AXI_RREADY) begin
      next_s.rvalid = 1'b0;
    end
    next_s.arready = !next_s.rvalid;
  end

  // --------------------------------------------------
  // State register
  // --------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign HORN          = s.horn;
  assign AMBER_LAMP    = s.amber;
  assign RED_LAMP      = s.red;
  assign CAN_SILENCE   = s.can_sil;
  assign SHUTDOWN      = s.shutdown;
  assign MODE          = s.mode;
  assign SAVE          = s.save;
  assign S_AXI_AWREADY = s.awready;
  assign S_AXI_WREADY  = s.wready;
  assign S_AXI_BVALID  = s.bvalid;
  assign S_AXI_BRESP   = s.bresp;
  assign S_AXI_ARREADY = s.arready;
  assign S_AXI_RVALID  = s.rvalid;
  assign S_AXI_RDATA   = s.rdata;
  assign S_AXI_RRESP   = s.rresp;
endmodule

// file: sim/pkal_checker.sv
`timescale 1ns/1ns
module pkal_checker
  import pkal_pkg::*;
#(
  parameter int unsigned DEB_CYC   = 4,
  parameter int unsigned BLINK_CYC = 8
) (
  // Clock and reset
  input wire logic                      CLK,
  input wire logic                      ARST_N,
  // Panel side
  input wire logic [pkal_pkg::NKEY-1:0] KEY,
  input wire logic [pkal_pkg::NEV-1:0]  WARN_ACTIVE,
  input wire logic [pkal_pkg::NEV-1:0]  SHUT_ACTIVE,
  input wire logic                      HORN,
  input wire logic                      RED_LAMP,
  input wire logic                      CAN_SILENCE,
  input wire logic                      SHUTDOWN,
  input wire logic [1:0]                MODE,
  input wire logic                      SAVE,
  // Register bus
  input wire logic                      S_AXI_AWVALID,
  input wire logic                      S_AXI_AWREADY,
  input wire logic                      S_AXI_WVALID,
  input wire logic                      S_AXI_WREADY,
  input wire logic [1:0]                S_AXI_BRESP,
  input wire logic                      S_AXI_BVALID,
  input wire logic                      S_AXI_ARVALID,
  input wire logic                      S_AXI_ARREADY,
  input wire logic                      S_AXI_RVALID
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // ---------------------------------------------
  // Panel rules
  // ---------------------------------------------
  a_horn_set: assert property ((|(WARN_ACTIVE & ~$past(WARN_ACTIVE))) |-> ##[1:2] HORN)
    else $error("horn not raised by new warning");
  a_horn_ack: assert property ($fell(HORN) |-> $past(KEY[K_ACK], 2))
    else $error("horn dropped without acknowledge");
  a_mode_key: assert property ($changed(MODE) |-> $past(KEY[K_RUN], 2) || $past(KEY[K_AUTO], 2) || $past(KEY[K_STOP], 2))
    else $error("mode changed without mode key");
  a_can_pulse: assert property (CAN_SILENCE |=> !CAN_SILENCE)
    else $error("silence request longer than one cycle");
  a_save_pulse: assert property (SAVE |=> !SAVE)
    else $error("save pulse longer than one cycle");
  a_shut_set: assert property ((|SHUT_ACTIVE) |-> ##2 SHUTDOWN)
    else $error("active shutdown not latched");
  a_shut_hold: assert property ($fell(SHUTDOWN) |-> $past(KEY[K_RESET], 2))
    else $error("shutdown cleared without event reset");
  a_red_off: assert property ((!(|SHUT_ACTIVE)) [*3] |-> !RED_LAMP)
    else $error("red lamp lit with no active shutdown");
  // ---------------------------------------------
  // Register bus
  // ---------------------------------------------
  a_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  a_wr_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID)
    else $error("write answer late");
  a_ready_low: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write ready during response");
  c_silence: cover property (CAN_SILENCE);
  c_save: cover property (SAVE);
  c_shut_clear: cover property ($fell(SHUTDOWN));
  c_refused: cover property (S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR);
endmodule
bind pkal_top pkal_checker #(.DEB_CYC(DEB_CYC), .BLINK_CYC(BLINK_CYC)) u_pkal_checker (
  .CLK, .ARST_N, .KEY, .WARN_ACTIVE, .SHUT_ACTIVE, .HORN, .RED_LAMP, .CAN_SILENCE, .SHUTDOWN, .MODE, .SAVE,
  .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
  .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID
);

// file: sim/pkal_operator.sv
`timescale 1ns/1ns
module pkal_operator
  import pkal_pkg::*;
#(
  parameter int unsigned DEB_CYC = 4
) (
  // Clock
  input wire logic                 clk,
  // Raw keys
  output logic [pkal_pkg::NKEY-1:0] key
);
  initial key = '0;
  // A short contact bounce first, then a long hold, so a weak debounce shows up as a double action
  task automatic press(input int k);
    @(posedge clk);
    key[k] <= 1'b1;
    @(posedge clk);
    key[k] <= 1'b0;
    @(posedge clk);
    key[k] <= 1'b1;
    repeat (3 * DEB_CYC + 4) @(posedge clk);
    key[k] <= 1'b0;
    repeat (2 * DEB_CYC + 4) @(posedge clk);
  endtask
endmodule

// file: sim/test_pkal_top.sv
`timescale 1ns/1ns
module test_pkal_top;
  import pkal_pkg::*;
  localparam int unsigned DEB = 4;
  logic              CLK, ARST_N, HORN, AMBER_LAMP, RED_LAMP, CAN_SILENCE, SHUTDOWN, SAVE;
  logic [NKEY-1:0]   KEY;
  logic [NEV-1:0]    WARN_ACTIVE, SHUT_ACTIVE;
  logic [2:0]        MODE_SW;
  logic [1:0]        MODE, S_AXI_BRESP, S_AXI_RRESP, rsp;
  logic [7:0]        S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0]       S_AXI_WDATA, S_AXI_RDATA, rdat;
  logic [3:0]        S_AXI_WSTRB;
  logic              S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic              S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, al;
  int                num_errors, samples_checked, can_cnt, save_cnt, cyc, tg;
  pkal_top #(.DEB_CYC(DEB), .BLINK_CYC(8)) u_pkal_top (
    .CLK, .ARST_N, .KEY, .WARN_ACTIVE, .SHUT_ACTIVE, .MODE_SW, .HORN, .AMBER_LAMP, .RED_LAMP, .CAN_SILENCE,
    .SHUTDOWN, .MODE, .SAVE, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY
  );
  pkal_operator #(.DEB_CYC(DEB)) u_pkal_operator (.clk(CLK), .key(KEY));
  initial CLK = 1'b0;
  always #2 CLK = ~CLK;
  // -------------------------------------------
  // Counting and closing
  // -------------------------------------------
  always @(posedge CLK) begin
    cyc++;
    if (CAN_SILENCE === 1'b1) can_cnt++;
    if (SAVE === 1'b1) save_cnt++;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // -------------------------------------------
  // Bus and key access
  // -------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
    rsp = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1);
    rdat = S_AXI_RDATA;
    rsp = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask
  task automatic pk(input int k);
    u_pkal_operator.press(k);
  endtask
  // -------------------------------------------
  // Tests
  // -------------------------------------------
  initial begin
    ARST_N <= 1'b0;
    {WARN_ACTIVE, SHUT_ACTIVE, MODE_SW, S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} <= '0;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} <= '0;
    S_AXI_WSTRB <= 4'hF;
    repeat (6) @(posedge CLK);
    ARST_N <= 1'b1;
    repeat (2) @(posedge CLK);
    rd(OFS_CTRL);
    chk(rdat, CTRL_RST);
    rd(8'h18);
    chk({rsp, rdat}, {RESP_SLVERR, 32'h0000_0000});
    wr(OFS_STATUS, 32'h0000_0003);
    chk(rsp, RESP_SLVERR);
    rd(OFS_STATUS);
    chk(rdat[1:0], PKAL_STOP);
    $display("test reset done");
    pk(K_RUN);
    chk(MODE, PKAL_RUN);
    pk(K_AUTO);
    chk(MODE, PKAL_AUTO);
    pk(K_STOP);
    chk(MODE, PKAL_STOP);
    pk(K_RUN);
    wr(OFS_CTRL, 32'h0000_0002);
    MODE_SW <= 3'b001;
    pk(K_AUTO);
    pk(K_STOP);
    chk(MODE, PKAL_RUN);
    MODE_SW <= 3'b000;
    pk(K_AUTO);
    chk(MODE, PKAL_AUTO);
    $display("test modes done");
    wr(OFS_CTRL, 32'h0000_0001);
    WARN_ACTIVE <= 8'h01;
    SHUT_ACTIVE <= 8'h02;
    repeat (4) @(posedge CLK);
    chk({HORN, SHUTDOWN}, 2'b11);
    rd(OFS_STATUS);
    chk(rdat[5:2], {LAMP_FLASH, LAMP_FLASH});
    tg = 0;
    al = AMBER_LAMP;
    repeat (20) begin
      @(posedge CLK);
      #1;
      chk(AMBER_LAMP, RED_LAMP);
      if (AMBER_LAMP !== al) tg++;
      al = AMBER_LAMP;
    end
    chk(tg >= 2, 1'b1);
    pk(K_ACK);
    chk({HORN, can_cnt}, {1'b0, 32'd1});
    rd(OFS_STATUS);
    chk(rdat[5:2], {LAMP_SOLID, LAMP_SOLID});
    pk(K_RESET);
    chk(SHUTDOWN, 1'b1);
    SHUT_ACTIVE <= 8'h00;
    repeat (4) @(posedge CLK);
    chk({RED_LAMP, SHUTDOWN}, 2'b01);
    pk(K_RESET);
    chk(SHUTDOWN, 1'b0);
    rd(OFS_WARN);
    chk(rdat[7:0], 8'h01);
    WARN_ACTIVE <= 8'h02;
    repeat (4) @(posedge CLK);
    WARN_ACTIVE <= 8'h00;
    repeat (4) @(posedge CLK);
    rd(OFS_STATUS);
    chk(rdat[3:2], LAMP_FLASH);
    pk(K_ACK);
    rd(OFS_STATUS);
    chk({rdat[3:2], can_cnt}, {LAMP_OFF, 32'd2});
    $display("test alarms done");
    wr(OFS_SETPT, 32'h0000_0009);
    wr(OFS_CTRL, 32'h0000_0010);
    pk(K_OK);
    rd(OFS_STATUS);
    chk(rdat[11], 1'b1);
    pk(K_UP);
    rd(OFS_EDIT);
    chk(rdat[3:0], 4'h0);
    pk(K_LEFT);
    rd(OFS_STATUS);
    chk(rdat[13:12], 2'h1);
    pk(K_DOWN);
    rd(OFS_EDIT);
    chk(rdat[15:0], 16'h0090);
    pk(K_OK);
    rd(OFS_SETPT);
    chk({save_cnt, rdat}, {32'd1, 32'h0000_0090});
    pk(K_OK);
    pk(K_UP);
    rd(OFS_STATUS);
    chk(rdat[10:8], 3'h2);
    pk(K_ESC);
    rd(OFS_STATUS);
    chk({rdat[11:8], save_cnt}, {1'b0, 3'h1, 32'd1});
    rd(OFS_SETPT);
    chk(rdat, 32'h0000_0090);
    wr(OFS_CTRL, 32'h0000_0030);
    pk(K_OK);
    pk(K_RIGHT);
    rd(OFS_EDIT);
    chk(rdat[20], 1'b1);
    pk(K_LEFT);
    rd(OFS_EDIT);
    chk(rdat[20], 1'b0);
    pk(K_RIGHT);
    pk(K_OK);
    rd(OFS_SETPT);
    chk(rdat[20], 1'b1);
    wr(OFS_CTRL, 32'h0000_0020);
    pk(K_OK);
    pk(K_UP);
    rd(OFS_EDIT);
    chk(rdat[19:16], 4'hF);
    pk(K_DOWN);
    rd(OFS_EDIT);
    chk(rdat[19:16], 4'h0);
    pk(K_ESC);
    $display("test editing done");
    wr(OFS_CTRL, 32'h0000_0000);
    rd(OFS_STATUS);
    chk(rdat[10:8], 3'h2);
    pk(K_OK);
    rd(OFS_STATUS);
    chk(rdat[10:8], 3'h3);
    pk(K_OK);
    pk(K_LOG);
    rd(OFS_STATUS);
    chk(rdat[19:18], 2'h3);
    pk(K_MENU);
    rd(OFS_STATUS);
    chk({rdat[19:18], rdat[10:8]}, 5'h00);
    pk(K_UP);
    rd(OFS_STATUS);
    chk(rdat[17:14], 4'hF);
    $display("test menus done");
    report_and_stop();
  end
endmodule
